// ### add_instruction_execute_test.sv
`timescale 1ns/1ns
`default_nettype none
`define CHK(g, x) begin tests_run++; if ((g) !== (x)) begin mismatches++; \
   $display("unexpected at %0t: got %h want %h", $time, g, x); end end
module add_instruction_execute_test;
   import aie_pkg::*;
   logic clk = 1'b0, nrst = 1'b0, valid = 1'b0, ext = 1'b0, ce = 1'b1;
   logic [INSTR_W-1:0] instr = 16'h0000;
   logic [BANK_W-1:0] bank_select_reg = 4'h0;
   logic [DATA_W-1:0] rdata, wdata, acc;
   logic [1:0] phase;
   logic busy, mem_rd, mem_wr, indexed, done;
   logic [DADDR_W-1:0] addr;
   logic [7:0] offset;
   logic [FLAGS_W-1:0] flags;
   int mismatches = 0, tests_run = 0;
   aie_add_exec dut_u (.CLK_I(clk), .NRST_I(nrst), .CE_I(ce),
      .INSTR_VALID_I(valid), .INSTR_I(instr), .EXT_SET_EN_I(ext),
      .BANK_SELECT_REG_I(bank_select_reg), .MEM_RDATA_I(rdata), .PHASE_O(phase),
      .BUSY_O(busy), .MEM_RD_O(mem_rd), .MEM_WR_O(mem_wr), .DONE_O(done),
      .MEM_ADDR_O(addr), .MEM_INDEXED_O(indexed), .MEM_OFFSET_O(offset),
      .MEM_WDATA_O(wdata), .ACC_O(acc), .FLAGS_O(flags));
   aie_mem_model mem_u (.clk_i(clk), .rd_i(mem_rd), .wr_i(mem_wr),
      .addr_i(addr), .wdata_i(wdata), .rdata_o(rdata));
   initial forever #20 clk = ~clk;
   ////////////////////////////////////////////////////////////////////////
   function automatic logic [12:0] ref_add(input logic [7:0] a,
      input logic [7:0] b);
      logic [8:0] s;
      logic [4:0] h;
      s = {1'b0, a} + {1'b0, b};
      h = {1'b0, a[3:0]} + {1'b0, b[3:0]};
      return {s[7], a[7] == b[7] && s[7] != a[7], s[7:0] == 8'h00, h[4],
         s[8], s[7:0]};
   endfunction : ref_add
   task automatic exec(input logic [15:0] w, input logic [7:0] b,
      input logic [3:0] bk, input logic x);
      logic [12:0] e;
      logic [7:0] a0;
      logic ix;
      a0 = acc;
      e = ref_add(acc, b);
      // indexed only for a register add in the access bank at low f
      ix = w[15:10] == OPC_ADD_REG && !w[8] && x && w[7:0] <= INDEXED_MAX;
      @(posedge clk);
      {instr, valid, bank_select_reg, ext} <= {w, 1'b1, bk, x};
      @(posedge clk);
      valid <= 1'b0;
      #1;
      `CHK(busy, 1'b1)
      `CHK(indexed, ix)
      repeat (3) @(posedge clk);
      #1;
      `CHK(done, 1'b1)
      `CHK(busy, 1'b0)
      `CHK(flags, e[12:8])
      `CHK(acc, (w[15:8] == OPC_ADD_IMM || !w[9]) ? e[7:0] : a0)
   endtask : exec
   task automatic t_literal;
      logic [7:0] lits [4] = '{8'h10, 8'h15, 8'h5B, 8'h80};
      foreach (lits[i]) exec({8'h0F, lits[i]}, lits[i], 4'h0, 1'b0);
      $display("literal done");
   endtask : t_literal
   task automatic t_register;
      mem_u.mem[12'hFC2] = 8'hC2;
      mem_u.mem[12'h020] = 8'h07;
      exec(16'h0F17, 8'h17, 4'h0, 1'b0);
      exec(16'h24C2, 8'hC2, 4'h0, 1'b0);
      `CHK(addr, 12'hFC2)
      exec(16'h2420, 8'h07, 4'h0, 1'b0);
      `CHK(addr, 12'h020)
      $display("register done");
   endtask : t_register
   task automatic t_bank;
      mem_u.mem[12'h520] = 8'h33;
      exec(16'h2720, 8'h33, 4'h5, 1'b0);
      `CHK(addr, 12'h520)
      `CHK(mem_u.mem[12'h520], 8'h13)
      `CHK(wdata, 8'h13)
      $display("bank done");
   endtask : t_bank
   task automatic t_indexed;
      mem_u.mem[12'h000] = 8'h01;
      mem_u.mem[12'hF60] = 8'h02;
      exec(16'h245F, 8'h01, 4'h3, 1'b1);
      `CHK(addr, 12'h000)
      `CHK(offset, 8'h5F)
      exec(16'h2460, 8'h02, 4'h3, 1'b1);
      `CHK(addr, 12'hF60)
      $display("indexed done");
   endtask : t_indexed
   task automatic t_refuse;
      logic [7:0] a0;
      a0 = acc;
      @(posedge clk);
      {instr, valid} <= {16'h0E55, 1'b1};
      repeat (5) @(posedge clk);
      valid <= 1'b0;
      #1;
      `CHK(phase, 2'h0)
      `CHK(acc, a0)
      $display("refuse done");
   endtask : t_refuse
   task automatic t_freeze;
      logic [7:0] a0;
      a0 = acc;
      @(posedge clk);
      {instr, valid, ce} <= {16'h0F21, 1'b1, 1'b0};
      repeat (3) @(posedge clk);
      {valid, ce} <= 2'b01;
      #1;
      `CHK(phase, 2'h0)
      `CHK(busy, 1'b0)
      `CHK(acc, a0)
      $display("freeze done");
   endtask : t_freeze
   task automatic t_reset;
      @(posedge clk);
      nrst <= 1'b0;
      repeat (2) @(posedge clk);
      nrst <= 1'b1;
      #1;
      `CHK(acc, ACC_RESET)
      `CHK(flags, FLAGS_RESET)
      `CHK(phase, 2'h0)
      exec(16'h0F15, 8'h15, 4'h0, 1'b0);
      `CHK(acc, 8'h15)
      $display("reset done");
   endtask : t_reset
   task automatic conclude;
      $display("comparisons %0d mismatches %0d", tests_run, mismatches);
      if (mismatches == 0 && tests_run > 0) $display("Finished cleanly");
      else $display("Finished with errors");
      $finish;
   endtask : conclude
   initial begin
      repeat (10) @(posedge clk);
      nrst <= 1'b1;
      t_literal();
      t_register();
      t_bank();
      t_indexed();
      t_refuse();
      t_freeze();
      t_reset();
      conclude();
   end
   // generous bound: the whole run needs under eighty cycles
   initial begin
      repeat (2000) @(posedge clk);
      mismatches++;
      conclude();
   end
endmodule : add_instruction_execute_test
bind aie_add_exec aie_exec_monitor mon_u (.CLK_I, .NRST_I, .CE_I,
   .INSTR_VALID_I, .INSTR_I, .EXT_SET_EN_I, .BANK_SELECT_REG_I, .PHASE_O,
   .MEM_RD_O, .MEM_WR_O, .MEM_ADDR_O, .MEM_INDEXED_O, .ACC_O, .DONE_O);
`default_nettype wire

// ### aie_add_exec.sv
`timescale 1ns/1ns
`default_nettype none
////////////////////////////////////////////////////////////////////////
// Contract
// - immediate add: acc plus literal into acc, flags
// - register add: acc plus data register, flags
// - dest bit 0 to acc, 1 to register
// - bank bit 0 access bank, else bank select
// - extended set, bank bit 0, addr<=95 indexed
// - one word, one cycle, four phases
module aie_add_exec
   import aie_pkg::*;
(
   input wire logic CLK_I,
   input wire logic NRST_I,
   input wire logic CE_I,
   input wire logic INSTR_VALID_I,
   input wire logic [INSTR_W-1:0] INSTR_I,
   input wire logic EXT_SET_EN_I,
   input wire logic [BANK_W-1:0] BANK_SELECT_REG_I,
   input wire logic [DATA_W-1:0] MEM_RDATA_I,
   output logic [1:0] PHASE_O,
   output logic BUSY_O,
   output logic MEM_RD_O,
   output logic MEM_WR_O,
   output logic [DADDR_W-1:0] MEM_ADDR_O,
   output logic MEM_INDEXED_O,
   output logic [7:0] MEM_OFFSET_O,
   output logic [DATA_W-1:0] MEM_WDATA_O,
   output logic [DATA_W-1:0] ACC_O,
   output logic [FLAGS_W-1:0] FLAGS_O,
   output logic DONE_O
);
   import aie_pkg::*;

   ////////////////////////////////////////////////////////////////////
   function automatic logic is_imm(input logic [INSTR_W-1:0] w);
      return w[OPC_IMM_HI:8] == OPC_ADD_IMM;
   endfunction : is_imm

   function automatic logic is_reg(input logic [INSTR_W-1:0] w);
      return w[OPC_IMM_HI:OPC_REG_LO] == OPC_ADD_REG;
   endfunction : is_reg

   ////////////////////////////////////////////////////////////////////
   aie_phase_e phase, next_phase;
   logic [INSTR_W-1:0] instr, next_instr;
   logic [DATA_W-1:0] operand, next_operand;
   logic [DATA_W-1:0] acc, next_acc;
   logic [FLAGS_W-1:0] flags, next_flags;
   logic busy, next_busy;
   logic mem_rd, next_mem_rd;
   logic mem_wr, next_mem_wr;
   logic [DADDR_W-1:0] mem_addr, next_mem_addr;
   logic mem_indexed, next_mem_indexed;
   logic [7:0] mem_offset, next_mem_offset;
   logic [DATA_W-1:0] mem_wdata, next_mem_wdata;
   logic done, next_done;
   logic [DATA_W-1:0] sum;
   logic [FLAGS_W-1:0] sum_flags;
   // decoded word, shared by the sequencer and the memory port
   logic word_take;
   logic word_reg;

   aie_adder u_adder (
      .a_i(acc),
      .b_i(operand),
      .sum_o(sum),
      .flags_o(sum_flags)
   );

   ////////////////////////////////////////////////////////////////////
   // a word that is neither add is not ours
   assign word_reg = INSTR_VALID_I && is_reg(INSTR_I);
   assign word_take = word_reg || (INSTR_VALID_I && is_imm(INSTR_I));

   ////////////////////////////////////////////////////////////////////
   // sequencer: one quarter phase per enabled edge
   always_comb begin
      next_phase = phase;
      next_instr = instr;
      next_busy = busy;
      next_done = 1'b0;
      unique case (phase)
         Q1_DECODE: begin
            // words are only looked at in Q1; others stay idle here
            if (word_take) begin
               next_instr = INSTR_I;
               next_busy = 1'b1;
               next_phase = Q2_READ;
            end
         end
         Q2_READ: begin
            next_phase = Q3_PROCESS;
         end
         Q3_PROCESS: begin
            next_phase = Q4_WRITE;
         end
         Q4_WRITE: begin
            // no stall: the next word may be taken right after Q4
            next_done = 1'b1;
            next_busy = 1'b0;
            next_phase = Q1_DECODE;
         end
      endcase
   end

   always_ff @(posedge CLK_I) begin
      if (!NRST_I) begin
         phase <= Q1_DECODE;
         instr <= '0;
         busy <= 1'b0;
         done <= 1'b0;
      end else if (CE_I) begin
         phase <= next_phase;
         instr <= next_instr;
         busy <= next_busy;
         done <= next_done;
      end
   end

   ////////////////////////////////////////////////////////////////////
   // memory port: address and read strobe in Q2, write strobe in Q4
   always_comb begin
      next_mem_rd = 1'b0;
      next_mem_wr = 1'b0;
      next_mem_addr = mem_addr;
      next_mem_indexed = mem_indexed;
      next_mem_offset = mem_offset;
      next_mem_wdata = mem_wdata;
      if (phase == Q1_DECODE && word_reg) begin
         next_mem_rd = 1'b1;
         next_mem_offset = INSTR_I[7:0];
         next_mem_indexed = 1'b0;
         if (INSTR_I[BANK_MODE_BIT]) begin
            next_mem_addr = {BANK_SELECT_REG_I, INSTR_I[7:0]};
         end else if (EXT_SET_EN_I && INSTR_I[7:0] <= INDEXED_MAX) begin
            // address is formed outside from the index pointer
            next_mem_indexed = 1'b1;
            next_mem_addr = '0;
         end else if (INSTR_I[7:0] < ACCESS_SPLIT) begin
            // access bank: low addresses to bank 0, high to the top bank
            next_mem_addr = {4'h0, INSTR_I[7:0]};
         end else begin
            next_mem_addr = {ACCESS_HI_BANK, INSTR_I[7:0]};
         end
      end
      if (phase == Q3_PROCESS) begin
         // sum settles from acc and operand; result staged for Q4
         next_mem_wdata = sum;
         next_mem_wr = is_reg(instr) && instr[DEST_BIT];
      end
      if (phase == Q4_WRITE) begin
         next_mem_indexed = 1'b0;
      end
   end

   always_ff @(posedge CLK_I) begin
      if (!NRST_I) begin
         mem_rd <= 1'b0;
         mem_wr <= 1'b0;
         mem_addr <= '0;
         mem_indexed <= 1'b0;
         mem_offset <= '0;
         mem_wdata <= '0;
      end else if (CE_I) begin
         mem_rd <= next_mem_rd;
         mem_wr <= next_mem_wr;
         mem_addr <= next_mem_addr;
         mem_indexed <= next_mem_indexed;
         mem_offset <= next_mem_offset;
         mem_wdata <= next_mem_wdata;
      end
   end

   ////////////////////////////////////////////////////////////////////
   // datapath: operand in Q2, accumulator and flags in Q4
   always_comb begin
      next_operand = operand;
      next_acc = acc;
      next_flags = flags;
      if (phase == Q2_READ) begin
         // operand is latched so memory may release its bus after Q2
         if (is_imm(instr)) begin
            next_operand = instr[7:0];
         end else begin
            next_operand = MEM_RDATA_I;
         end
      end
      if (phase == Q4_WRITE) begin
         // flags follow every add, even when the sum goes to memory
         next_flags = sum_flags;
         if (is_imm(instr) || !instr[DEST_BIT]) begin
            next_acc = sum;
         end
      end
   end

   always_ff @(posedge CLK_I) begin
      if (!NRST_I) begin
         operand <= '0;
         acc <= ACC_RESET;
         flags <= FLAGS_RESET;
      end else if (CE_I) begin
         operand <= next_operand;
         acc <= next_acc;
         flags <= next_flags;
      end
   end

   ////////////////////////////////////////////////////////////////////
   assign PHASE_O = phase;
   assign BUSY_O = busy;
   assign MEM_RD_O = mem_rd;
   assign MEM_WR_O = mem_wr;
   assign MEM_ADDR_O = mem_addr;
   assign MEM_INDEXED_O = mem_indexed;
   assign MEM_OFFSET_O = mem_offset;
   assign MEM_WDATA_O = mem_wdata;
   assign ACC_O = acc;
   assign FLAGS_O = flags;
   assign DONE_O = done;
endmodule : aie_add_exec
`default_nettype wire

// ### aie_adder.sv
`timescale 1ns/1ns
`default_nettype none
module aie_adder
   import aie_pkg::*;
(
   input wire logic [DATA_W-1:0] a_i,
   input wire logic [DATA_W-1:0] b_i,
   output logic [DATA_W-1:0] sum_o,
   output logic [FLAGS_W-1:0] flags_o
);
   logic [DATA_W:0] full;
   logic [4:0] low;
   always_comb begin
      full = {1'b0, a_i} + {1'b0, b_i};
      low = {1'b0, a_i[3:0]} + {1'b0, b_i[3:0]};
      sum_o = full[DATA_W-1:0];
      flags_o = '0;
      flags_o[FLAG_C] = full[DATA_W];
      flags_o[FLAG_DC] = low[4];
      flags_o[FLAG_Z] = (full[DATA_W-1:0] == 8'h00);
      // signed overflow: operands agree in sign, sum differs
      flags_o[FLAG_OV] = (a_i[7] == b_i[7]) && (full[7] != a_i[7]);
      flags_o[FLAG_N] = full[7];
   end
endmodule : aie_adder
`default_nettype wire

// ### aie_exec_monitor.sv
`timescale 1ns/1ns
`default_nettype none
module aie_exec_monitor
   import aie_pkg::*;
(
   input wire logic CLK_I,
   input wire logic NRST_I,
   input wire logic CE_I,
   input wire logic INSTR_VALID_I,
   input wire logic [INSTR_W-1:0] INSTR_I,
   input wire logic EXT_SET_EN_I,
   input wire logic [BANK_W-1:0] BANK_SELECT_REG_I,
   input wire logic [1:0] PHASE_O,
   input wire logic MEM_RD_O,
   input wire logic MEM_WR_O,
   input wire logic [DADDR_W-1:0] MEM_ADDR_O,
   input wire logic MEM_INDEXED_O,
   input wire logic [DATA_W-1:0] ACC_O,
   input wire logic DONE_O
);
   default clocking @(posedge CLK_I); endclocking
   default disable iff (!NRST_I);
   logic imm, rg, take, dbit;
   logic [DADDR_W-1:0] bank_addr;
   logic [DATA_W-1:0] imm_sum;
   assign imm = INSTR_I[15:8] == OPC_ADD_IMM;
   assign rg = INSTR_I[15:10] == OPC_ADD_REG;
   assign take = CE_I && INSTR_VALID_I && PHASE_O == 2'h0 && (imm || rg);
   assign dbit = INSTR_I[DEST_BIT];
   assign bank_addr = {BANK_SELECT_REG_I, INSTR_I[7:0]};
   assign imm_sum = ACC_O + INSTR_I[7:0];
   a_done_four_q: assert property (take |-> ##4 DONE_O)
      else $error("done not on the fourth phase");
   a_phase_walk: assert property (take |=> PHASE_O == 2'h1 ##1
      PHASE_O == 2'h2 ##1 PHASE_O == 2'h3 ##1 PHASE_O == 2'h0)
      else $error("phase order broken");
   a_reg_read: assert property (take && rg |=> MEM_RD_O)
      else $error("no operand read");
   a_imm_no_mem: assert property (
      take && imm |=> (!MEM_RD_O && !MEM_WR_O) [*4])
      else $error("memory touched by immediate add");
   a_dest_write: assert property (
      take && rg |-> ##3 MEM_WR_O == $past(dbit, 3))
      else $error("write does not follow destination");
   a_bank_addr: assert property (
      take && rg && INSTR_I[BANK_MODE_BIT] |=> MEM_ADDR_O == $past(bank_addr))
      else $error("bank select address wrong");
   a_indexed_lo: assert property (take && rg && EXT_SET_EN_I
      && !INSTR_I[BANK_MODE_BIT] && INSTR_I[7:0] <= INDEXED_MAX
      |=> MEM_INDEXED_O && MEM_ADDR_O == 12'h000)
      else $error("indexed mode missed");
   a_imm_sum: assert property (
      take && imm |-> ##4 ACC_O == $past(imm_sum, 4))
      else $error("immediate sum wrong");
   a_frozen_hold: assert property (
      !CE_I |=> $stable(PHASE_O) && $stable(ACC_O))
      else $error("state moved with enable low");
   cover property (take && imm);
   cover property (!CE_I && INSTR_VALID_I);
   cover property (take && rg && dbit);
   cover property (take && rg && EXT_SET_EN_I);
endmodule : aie_exec_monitor
`default_nettype wire

// ### aie_mem_model.sv
`timescale 1ns/1ns
`default_nettype none
module aie_mem_model
   import aie_pkg::*;
(
   input wire logic clk_i,
   input wire logic rd_i,
   input wire logic wr_i,
   input wire logic [DADDR_W-1:0] addr_i,
   input wire logic [DATA_W-1:0] wdata_i,
   output logic [DATA_W-1:0] rdata_o
);
   logic [DATA_W-1:0] mem [0:4095];
   logic [DATA_W-1:0] last = 8'h00;
   // released bus shows the inverse so a stale sample cannot pass
   assign rdata_o = rd_i ? mem[addr_i] : ~last;
   always @(posedge clk_i) begin
      if (rd_i) last <= mem[addr_i];
      if (wr_i) mem[addr_i] <= wdata_i;
   end
endmodule : aie_mem_model
`default_nettype wire

// ### aie_pkg.sv
package aie_pkg;
   localparam int DATA_W = 8;
   localparam int INSTR_W = 16;
   localparam int BANK_W = 4;
   localparam int DADDR_W = 12;
   // opcode patterns on the upper bits of the instruction word
   localparam logic [7:0] OPC_ADD_IMM = 8'h0F;
   localparam logic [5:0] OPC_ADD_REG = 6'h09;
   localparam int OPC_IMM_HI = 15;
   localparam int OPC_REG_LO = 10;
   localparam int DEST_BIT = 9;
   localparam int BANK_MODE_BIT = 8;
   // indexed literal offset applies up to this address field value
   localparam logic [7:0] INDEXED_MAX = 8'h5F;
   // access bank split: addresses below this to bank 0, the rest to the top bank
   localparam logic [7:0] ACCESS_SPLIT = 8'h60;
   localparam logic [3:0] ACCESS_HI_BANK = 4'hF;
   // status bit positions
   localparam int FLAG_C = 0;
   localparam int FLAG_DC = 1;
   localparam int FLAG_Z = 2;
   localparam int FLAG_OV = 3;
   localparam int FLAG_N = 4;
   localparam int FLAGS_W = 5;
   localparam logic [7:0] ACC_RESET = 8'h00;
   localparam logic [4:0] FLAGS_RESET = 5'h00;
   typedef enum logic [1:0] {
      Q1_DECODE = 2'b00,
      Q2_READ = 2'b01,
      Q3_PROCESS = 2'b10,
      Q4_WRITE = 2'b11
   } aie_phase_e;
endpackage : aie_pkg
